// ==== rtl/lrg_map.svh ====
// constants of the led current regulator: widths, timing and fixed values
`ifndef LRG_MAP_SVH
`define LRG_MAP_SVH

`define LRG_ADC_W        10
`define LRG_COEF_W       16
`define LRG_FRAC_W       10
`define LRG_PWM_W        8
`define LRG_DUTY_W       18
`define LRG_ERR_W        11
`define LRG_PROD_W       27
`define LRG_INCR_W       28
`define LRG_SUM_W        30
`define LRG_SLOT_W       2

`define LRG_CLK_MHZ      10
`define LRG_SLOT_US      200
`define LRG_LOOPS        4
`define LRG_ZERO_HZ      500
`define LRG_US_PER_S     1000000
`define LRG_SLOT_CYCLES  (`LRG_SLOT_US * `LRG_CLK_MHZ)

`define LRG_PERIOD_VALUE 8'hff
`define LRG_LED_SLOT     2'h0
`define LRG_DUTY_ZERO    18'h00000
`define LRG_ERR_ZERO     11'sh000

`endif

// ==== rtl/lrg_pkg.sv ====
// types shared by the led current regulator modules
`include "lrg_map.svh"
package lrg_pkg;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_FETCH,
        ST_PREMUL,
        ST_WAIT,
        ST_CHECK,
        ST_CLAMP,
        ST_WR_DUTY,
        ST_WR_CYCLE
    } lrg_state_t;

    typedef struct packed {
        logic signed [`LRG_COEF_W-1:0] a1;
        logic signed [`LRG_COEF_W-1:0] a2;
        logic        [`LRG_DUTY_W-1:0] duty_max;
        logic        [`LRG_DUTY_W-1:0] duty_min;
        logic        [`LRG_ADC_W-1:0]  over_limit;
    } lrg_cfg_t;

    typedef struct packed {
        logic                  duty_wr;
        logic [`LRG_PWM_W-1:0] led_duty_compare;
        logic                  cycle_wr;
        logic [`LRG_PWM_W-1:0] pwm_cycle_compare;
    } lrg_pwm_t;

    typedef struct packed {
        lrg_state_t                    state;
        logic        [`LRG_ADC_W-1:0]  target;
        logic        [`LRG_ADC_W-1:0]  meas;
        logic signed [`LRG_ERR_W-1:0]  err_prev;
        logic signed [`LRG_PROD_W-1:0] prod2;
        logic        [`LRG_DUTY_W-1:0] duty;
        logic                          conv_start;
        lrg_pwm_t                      pwm;
        logic                          led_stop;
        logic                          pfc_stop;
        logic                          busy;
    } lrg_regs_t;

    typedef struct packed {
        logic                   go;
        logic [`LRG_SLOT_W-1:0] slot;
        logic [15:0]            cnt;
    } lrg_slot_regs_t;

endpackage

// ==== rtl/lrg_slot_timer.sv ====
// slot sequencer: one enable pulse every LOOPS slots and the index of the loop being served
`timescale 1ns/1ns
`include "lrg_map.svh"
module lrg_slot_timer #(
    parameter int SLOT_CYCLES = `LRG_SLOT_CYCLES,
    parameter int LOOPS       = `LRG_LOOPS
) (
    input  wire logic                   clk_i,   // timer count clock
    input  wire logic                   arst_n_i, // async reset, active low
    output logic                        go_o,    // pulse at start of our slot
    output logic [`LRG_SLOT_W-1:0]      slot_o   // loop index of current slot
);

    generate
        if (SLOT_CYCLES < 2 || SLOT_CYCLES > 65536) begin : g_bad_slot
            $error("slot length out of range");
        end
        if (LOOPS != (1 << `LRG_SLOT_W)) begin : g_bad_loops
            $error("loop count must match slot index width");
        end
    endgenerate

    lrg_pkg::lrg_slot_regs_t r_reg;
    lrg_pkg::lrg_slot_regs_t r_next;

    always_comb begin
        r_next    = r_reg;
        r_next.go = 1'b0;
        if (r_reg.cnt == 16'(SLOT_CYCLES - 1)) begin
            r_next.cnt  = 16'h0000;
            r_next.slot = r_reg.slot + 2'h1;
            // our loop owns slot 0, so it runs once every LOOPS slots
            r_next.go   = (r_next.slot == `LRG_LED_SLOT);
        end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg <= '{go: 1'b0, slot: 2'h3, cnt: 16'h0000};
        end else begin
            r_reg <= r_next;
        end
    end

    assign go_o   = r_reg.go;
    assign slot_o = r_reg.slot;

endmodule // lrg_slot_timer

// ==== rtl/lrg_pi_regulator.sv ====
// led current pi regulator: drives the converter and the pwm timer of the led channel
`timescale 1ns/1ns
`include "lrg_map.svh"

// How it works
// - brightness changes only via target code
// - start conversion, then fetch target code
// - compute a2 times previous error during conversion
// - overcurrent stops led and pfc, skips update
// - increment is a1*e(n) plus a2*e(n-1)
// - add increment to duty, clamp to limits
// - write new duty to duty compare
// - rewrite unchanged cycle value to apply duty
// - upper limit never exceeds full period
// - lower limit never below zero on-time
// - both coefficients are configurable constants
// - loop cycle below half zero period
// - four loops, 200 us slots, 800 us cycle
// - proportional constant below inverse loop gain
// - new duty = old + a1*e(n) + a2*e(n-1)
// - error is target minus measurement
// - cycle register value is 255
module lrg_pi_regulator #(
    parameter int SLOT_CYCLES = `LRG_SLOT_CYCLES,
    parameter int LOOPS       = `LRG_LOOPS,
    parameter int SLOT_US     = `LRG_SLOT_US,
    parameter int ZERO_HZ     = `LRG_ZERO_HZ
) (
    input  wire logic                   REF_CLK_I,     // timer count clock, 10 mhz
    input  wire logic                   ARST_N_I,      // async reset, active low
    input  wire logic                   ENABLE_I,      // run the loop
    input  wire logic                   CLEAR_STOP_I,  // pulse: release after overcurrent
    input  wire logic [`LRG_ADC_W-1:0]  TARGET_I,      // current target code
    input  wire lrg_pkg::lrg_cfg_t      CFG_I,         // coefficients, limits, threshold
    input  wire logic                   CONV_DONE_I,   // pulse: conversion finished
    input  wire logic [`LRG_ADC_W-1:0]  CONV_RESULT_I, // conversion_result
    output logic                        CONV_START_O,  // pulse: start sense conversion
    output lrg_pkg::lrg_pwm_t           PWM_O,         // compare register writes
    output logic                        LED_STOP_O,    // stop led_pwm_output
    output logic                        PFC_STOP_O,    // stop power-factor output
    output logic                        BUSY_O,        // iteration in progress
    output logic [`LRG_SLOT_W-1:0]      SLOT_O         // loop index of current slot
);

    // the loop cycle must stay under half the zero-point period
    generate
        if (SLOT_US * LOOPS * 2 * ZERO_HZ >= `LRG_US_PER_S) begin : g_bad_cycle
            $error("feedback cycle too long for zero-point frequency");
        end
    endgenerate

    lrg_pkg::lrg_regs_t r_reg;
    lrg_pkg::lrg_regs_t r_next;

    logic                          slot_go;
    logic signed [`LRG_ERR_W-1:0]  err_now;
    logic signed [`LRG_SUM_W-1:0]  duty_sum;
    logic signed [`LRG_INCR_W-1:0] incr;

    // coefficient times error; coefficients carry the duty's fraction bits
    function automatic logic signed [`LRG_PROD_W-1:0] coef_mul(
        input logic signed [`LRG_COEF_W-1:0] coef,
        input logic signed [`LRG_ERR_W-1:0]  err
    );
        coef_mul = coef * err;
    endfunction

    lrg_slot_timer #(
        .SLOT_CYCLES (SLOT_CYCLES),
        .LOOPS       (LOOPS)
    ) u_slot (
        .clk_i    (REF_CLK_I),
        .arst_n_i (ARST_N_I),
        .go_o     (slot_go),
        .slot_o   (SLOT_O)
    );

    always_comb begin
        err_now  = $signed({1'b0, r_reg.target}) - $signed({1'b0, r_reg.meas});
        // a1 and a2 are taken from configuration as held constants
        // stability rests on the user keeping (a1 - a2) / 2 under the inverse loop gain
        incr     = `LRG_INCR_W'(coef_mul(CFG_I.a1, err_now))
                 + `LRG_INCR_W'(r_reg.prod2);
        duty_sum = $signed({12'h000, r_reg.duty}) + `LRG_SUM_W'(incr);

        r_next                = r_reg;
        r_next.conv_start     = 1'b0;
        r_next.pwm.duty_wr    = 1'b0;
        r_next.pwm.cycle_wr   = 1'b0;

        case (r_reg.state)
            lrg_pkg::ST_IDLE: begin
                r_next.busy = 1'b0;
                // clear and set never meet: a stop is only raised in ST_CHECK
                if (CLEAR_STOP_I) begin
                    r_next.led_stop = 1'b0;
                    r_next.pfc_stop = 1'b0;
                end
                if (slot_go && ENABLE_I && !r_reg.led_stop && !CLEAR_STOP_I) begin
                    r_next.busy  = 1'b1;
                    r_next.state = lrg_pkg::ST_START;
                end
            end
            lrg_pkg::ST_START: begin
                r_next.conv_start = 1'b1;
                r_next.state      = lrg_pkg::ST_FETCH;
            end
            lrg_pkg::ST_FETCH: begin
                // brightness follows whatever target is current here
                r_next.target = TARGET_I;
                if (CONV_DONE_I) begin
                    r_next.meas = CONV_RESULT_I;
                end
                r_next.state  = lrg_pkg::ST_PREMUL;
            end
            lrg_pkg::ST_PREMUL: begin
                r_next.prod2 = coef_mul(CFG_I.a2, r_reg.err_prev);
                r_next.state = lrg_pkg::ST_WAIT;
                if (CONV_DONE_I) begin
                    r_next.meas  = CONV_RESULT_I;
                    r_next.state = lrg_pkg::ST_CHECK;
                end
            end
            lrg_pkg::ST_WAIT: begin
                if (CONV_DONE_I) begin
                    r_next.meas  = CONV_RESULT_I;
                    r_next.state = lrg_pkg::ST_CHECK;
                end
            end
            lrg_pkg::ST_CHECK: begin
                if (r_reg.meas > CFG_I.over_limit) begin
                    r_next.led_stop = 1'b1;
                    r_next.pfc_stop = 1'b1;
                    // restart from zero duty, as a fresh start would
                    r_next.duty     = `LRG_DUTY_ZERO;
                    r_next.err_prev = `LRG_ERR_ZERO;
                    r_next.state    = lrg_pkg::ST_IDLE;
                end else begin
                    r_next.state = lrg_pkg::ST_CLAMP;
                end
            end
            lrg_pkg::ST_CLAMP: begin
                // the duty width spans 0..full period, so the limits cannot leave it
                if (duty_sum > $signed({12'h000, CFG_I.duty_max})) begin
                    r_next.duty = CFG_I.duty_max;
                end else if (duty_sum < $signed({12'h000, CFG_I.duty_min})) begin
                    r_next.duty = CFG_I.duty_min;
                end else begin
                    r_next.duty = duty_sum[`LRG_DUTY_W-1:0];
                end
                r_next.err_prev = err_now;
                r_next.state    = lrg_pkg::ST_WR_DUTY;
            end
            lrg_pkg::ST_WR_DUTY: begin
                r_next.pwm.duty_wr          = 1'b1;
                r_next.pwm.led_duty_compare = `LRG_PERIOD_VALUE
                    - r_reg.duty[`LRG_DUTY_W-1:`LRG_FRAC_W];
                r_next.state                = lrg_pkg::ST_WR_CYCLE;
            end
            lrg_pkg::ST_WR_CYCLE: begin
                // the timer only takes the new duty once the cycle register is written
                r_next.pwm.cycle_wr          = 1'b1;
                r_next.pwm.pwm_cycle_compare = `LRG_PERIOD_VALUE;
                r_next.busy                  = 1'b0;
                r_next.state                 = lrg_pkg::ST_IDLE;
            end
            default: begin
                r_next.state = lrg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_reg.state                 <= lrg_pkg::ST_IDLE;
            r_reg.target                <= 10'h000;
            r_reg.meas                  <= 10'h000;
            r_reg.err_prev              <= `LRG_ERR_ZERO;
            r_reg.prod2                 <= 27'sh0000000;
            r_reg.duty                  <= `LRG_DUTY_ZERO;
            r_reg.conv_start            <= 1'b0;
            r_reg.pwm.duty_wr           <= 1'b0;
            r_reg.pwm.led_duty_compare  <= `LRG_PERIOD_VALUE;
            r_reg.pwm.cycle_wr          <= 1'b0;
            r_reg.pwm.pwm_cycle_compare <= `LRG_PERIOD_VALUE;
            r_reg.led_stop              <= 1'b0;
            r_reg.pfc_stop              <= 1'b0;
            r_reg.busy                  <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign CONV_START_O = r_reg.conv_start;
    assign PWM_O        = r_reg.pwm;
    assign LED_STOP_O   = r_reg.led_stop;
    assign PFC_STOP_O   = r_reg.pfc_stop;
    assign BUSY_O       = r_reg.busy;

endmodule // lrg_pi_regulator

// ==== sim/lrg_pi_regulator_monitor.sv ====
// assertion checker on the led current regulator ports
`timescale 1ns/1ns
`include "lrg_map.svh"
module lrg_pi_regulator_monitor (
    input wire logic                 REF_CLK_I,     // count clock
    input wire logic                 ARST_N_I,      // async reset, active low
    input wire logic                 CLEAR_STOP_I,  // stop release pulse
    input wire lrg_pkg::lrg_cfg_t    CFG_I,         // limits and threshold
    input wire logic                 CONV_DONE_I,   // conversion finished
    input wire logic [`LRG_ADC_W-1:0] CONV_RESULT_I, // conversion result
    input wire logic                 CONV_START_O,  // conversion request
    input wire lrg_pkg::lrg_pwm_t    PWM_O,         // compare writes
    input wire logic                 LED_STOP_O,    // led stop
    input wire logic                 PFC_STOP_O,    // pfc stop
    input wire logic                 BUSY_O         // iteration running
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    property p_start;
        $rose(BUSY_O) |=> CONV_START_O;
    endproperty
    property p_pulse;
        CONV_START_O |=> !CONV_START_O;
    endproperty
    // a done in the start or fetch cycle is not a result of this iteration
    property p_stop;
        CONV_DONE_I && BUSY_O && !CONV_START_O && !$rose(BUSY_O)
            && (CONV_RESULT_I > CFG_I.over_limit) |-> ##2 LED_STOP_O && PFC_STOP_O;
    endproperty
    property p_wr;
        CONV_DONE_I && BUSY_O && !CONV_START_O && !$rose(BUSY_O) && !LED_STOP_O
            && (CONV_RESULT_I <= CFG_I.over_limit) |-> ##4 PWM_O.duty_wr;
    endproperty
    property p_nowr;
        LED_STOP_O |-> !PWM_O.duty_wr && !PWM_O.cycle_wr;
    endproperty
    property p_sticky;
        LED_STOP_O && !CLEAR_STOP_I |=> LED_STOP_O && PFC_STOP_O;
    endproperty
    property p_cyc;
        PWM_O.duty_wr |=> PWM_O.cycle_wr && PWM_O.pwm_cycle_compare == 8'hff && !BUSY_O;
    endproperty
    property p_hold;
        !PWM_O.duty_wr |-> $stable(PWM_O.led_duty_compare);
    endproperty
    a_start: assert property (p_start) else $error("no conversion after start");
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    a_stop: assert property (p_stop) else $error("overcurrent not stopped");
    a_wr: assert property (p_wr) else $error("duty write late or missing");
    a_nowr: assert property (p_nowr) else $error("pwm written while stopped");
    a_sticky: assert property (p_sticky) else $error("stop released early");
    a_cyc: assert property (p_cyc) else $error("cycle rewrite wrong");
    a_hold: assert property (p_hold) else $error("duty compare moved");
    c_wr: cover property (PWM_O.duty_wr);
    c_stop: cover property ($rose(LED_STOP_O));
    c_clear: cover property (LED_STOP_O ##1 !LED_STOP_O);
endmodule // lrg_pi_regulator_monitor

// ==== sim/lrg_conv_model.sv ====
// converter model: answers each start after a set number of cycles
`timescale 1ns/1ns
`include "lrg_map.svh"
module lrg_conv_model (
    input  wire logic                  clk_i,    // count clock
    input  wire logic                  arst_n_i, // async reset, active low
    input  wire logic                  start_i,  // conversion request
    input  wire logic [`LRG_ADC_W-1:0] meas_i,   // level to convert
    input  wire logic [3:0]            lat_i,    // conversion time, at least 1
    output logic                       done_o,   // result valid pulse
    output logic [`LRG_ADC_W-1:0]      res_o     // conversion result
);
    logic [3:0]            cnt_reg;
    logic [`LRG_ADC_W-1:0] hold_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 4'h0;
            done_o <= 1'b0;
            hold_reg <= '0;
        end else begin
            done_o <= (cnt_reg == 4'h1);
            if (start_i)
                cnt_reg <= lat_i;
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1)
                hold_reg <= meas_i;
        end
    end
    // result is only valid with done; otherwise show garbage
    assign res_o = done_o ? hold_reg : ~hold_reg;
endmodule // lrg_conv_model

// ==== sim/lrg_pi_regulator_bench.sv ====
// self-checking bench for the led current regulator
`timescale 1ns/1ns
`include "lrg_map.svh"
module lrg_pi_regulator_bench;
    localparam int SC = 20;
    localparam int A1 = 144;
    localparam int A2 = 16;
    logic                    clk, arst_n, clr, done, start, led_stop, pfc_stop, busy, en;
    logic [1:0]              slot;
    logic [`LRG_ADC_W-1:0]   tgt, res, meas;
    logic [3:0]              lat;
    lrg_pkg::lrg_cfg_t       cfg;
    lrg_pkg::lrg_pwm_t       pwm;
    int                      n_errors, num_checks, duty, ep, dmax, dmin, gap, tst;
    lrg_pi_regulator #(.SLOT_CYCLES(SC)) dut_u (
        .REF_CLK_I(clk), .ARST_N_I(arst_n), .ENABLE_I(en), .CLEAR_STOP_I(clr),
        .TARGET_I(tgt), .CFG_I(cfg), .CONV_DONE_I(done), .CONV_RESULT_I(res),
        .CONV_START_O(start), .PWM_O(pwm), .LED_STOP_O(led_stop),
        .PFC_STOP_O(pfc_stop), .BUSY_O(busy), .SLOT_O(slot));
    lrg_conv_model conv_u (.clk_i(clk), .arst_n_i(arst_n), .start_i(start),
        .meas_i(meas), .lat_i(lat), .done_o(done), .res_o(res));
    task close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wt(input bit w);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (i < 300 && (w ? led_stop : pwm.duty_wr) !== 1'b1);
        chk(18'(i < 300), 18'h1);
    endtask
    // one regulation step; the expected duty follows the loop equation
    task iter(input int t, input int m, input logic [3:0] l);
        int s;
        @(posedge clk);
        tgt <= t[9:0];
        meas <= m[9:0];
        lat <= l;
        s = duty + A1 * (t - m) + A2 * ep;
        if (s > dmax) s = dmax;
        if (s < dmin) s = dmin;
        duty = s;
        ep = t - m;
        wt(1'b0);
        chk(pwm.led_duty_compare, 18'(8'hff - s[17:10]));
        @(negedge clk);
        chk(pwm.cycle_wr, 18'h1);
        chk(pwm.pwm_cycle_compare, 18'hff);
    endtask
    always @(negedge clk) if (start === 1'b1) begin
        gap = int'($time) - tst;
        tst = int'($time);
        chk(18'(slot), 18'h0);
    end
    task t_track;
        iter(337, 300, 4'h2);
        iter(337, 320, 4'h9);
        chk(gap[17:0], 18'(4 * SC * 100));
        iter(96, 150, 4'h2);
        $display("test track done");
    endtask
    task t_clamp;
        @(posedge clk);
        cfg.duty_max <= 18'h0c800;
        cfg.duty_min <= 18'h00400;
        dmax = 'h0c800;
        dmin = 'h00400;
        iter(900, 0, 4'h3);
        iter(0, 500, 4'h2);
        iter(512, 512, 4'h2);
        $display("test clamp done");
    endtask
    task t_oc;
        @(posedge clk);
        meas <= 10'h3ff;
        wt(1'b1);
        chk(pfc_stop, 18'h1);
        repeat (200) begin
            @(negedge clk);
            if (pwm.duty_wr === 1'b1 || start === 1'b1) chk(18'h1, 18'h0);
        end
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(negedge clk);
        chk(led_stop, 18'h0);
        duty = 0;
        ep = 0;
        iter(337, 300, 4'h2);
        $display("test overcurrent done");
    endtask
    // with the loop disabled no slot may start an iteration
    task t_enable;
        @(posedge clk);
        en <= 1'b0;
        repeat (8 * SC) begin
            @(negedge clk);
            if (start === 1'b1) chk(18'h1, 18'h0);
        end
        @(posedge clk);
        en <= 1'b1;
        iter(337, 300, 4'h2);
        $display("test enable done");
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3000000;
        n_errors++;
        close_out;
    end
    initial begin
        {arst_n, clr, tgt, meas, lat, n_errors, num_checks, duty, ep, dmin, tst} = '0;
        en = 1'b1;
        dmax = 'h3fc00;
        cfg = '{16'sh0090, 16'sh0010, 18'h3fc00, 18'h00000, 10'h200};
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_track;
        t_clamp;
        t_oc;
        t_enable;
        close_out;
    end
endmodule // lrg_pi_regulator_bench
bind lrg_pi_regulator lrg_pi_regulator_monitor mon_u (.REF_CLK_I, .ARST_N_I, .CLEAR_STOP_I,
    .CFG_I, .CONV_DONE_I, .CONV_RESULT_I, .CONV_START_O, .PWM_O, .LED_STOP_O,
    .PFC_STOP_O, .BUSY_O);
